// *** src/vtce_regs.svh ***
// Constants for the VLAN classify and tag edit block.
// Assumes inclusion by bare name from the package and the tag edit module.
`ifndef VTCE_REGS_SVH
`define VTCE_REGS_SVH

// Tag protocol identifiers
`define VTCE_TPID_CUSTOMER    16'h8100
`define VTCE_TPID_SERVICE     16'h88A8

// Field widths and layout of the tag control word
`define VTCE_VID_W            12
`define VTCE_PCP_W            3
`define VTCE_VID_COUNT        4096
`define VTCE_CFI_VALUE        1'h0

// Frame layout, in bytes
`define VTCE_MAC_BYTES        5'h0C
`define VTCE_HDR_BYTES        5'h10
`define VTCE_TPID_HI_POS      4'hC
`define VTCE_TPID_LO_POS      4'hD
`define VTCE_TCI_HI_POS       4'hE
`define VTCE_TCI_LO_POS       4'hF
`define VTCE_LAST_TAG_BYTE    2'h3
`define VTCE_LAST_FCS_BYTE    2'h3

// Frame check sequence
`define VTCE_CRC_INIT         32'hFFFFFFFF
`define VTCE_CRC_POLY         32'hEDB88320

// Default port count
`define VTCE_PORTS            10

`endif

// *** src/vtce_pkg.sv ***
// Types shared by the VLAN classify and tag edit block.
// Assumes vtce_regs.svh is reachable on the include path.
`include "vtce_regs.svh"

package vtce_pkg;

  // Frame handling sequence
  typedef enum logic [3:0]
  {
    VTCE_S_HDR  = 4'h0,
    VTCE_S_LOOK = 4'h1,
    VTCE_S_DEC  = 4'h2,
    VTCE_S_MAC  = 4'h3,
    VTCE_S_INS  = 4'h4,
    VTCE_S_REST = 4'h5,
    VTCE_S_BODY = 4'h6,
    VTCE_S_FCS  = 4'h7,
    VTCE_S_DROP = 4'h8
  } vtce_state_e;

  // Egress tag edit
  typedef enum logic [1:0]
  {
    VTCE_A_KEEP = 2'h0,
    VTCE_A_INS  = 2'h1,
    VTCE_A_DEL  = 2'h2
  } vtce_act_e;

  typedef logic [`VTCE_VID_W-1:0] vtce_vid_t;

endpackage

// *** src/vtce_vlan_table.sv ***
// Per-VLAN table: member port map and learning disable, one word per VID.
// Assumes one clock; contents are undefined until software writes them.
`timescale 1ns/1ps
`default_nettype none

module vtce_vlan_table #(
  parameter int unsigned DW = 11,
  parameter int unsigned AW = 12
) (
  input  wire logic          clk_sys_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem_r [2**AW];

  // Write port
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys_in)
  begin
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule

`default_nettype wire

// *** src/vtce_vlan_tag_edit.sv ***
// VLAN classification and egress tag edit for one frame stream.
// Assumes frames arrive without FCS, one byte per beat, and that the
// forwarding engine names the egress port with the first byte.
`timescale 1ns/1ps
`default_nettype none
`include "vtce_regs.svh"

module vtce_vlan_tag_edit #(
  parameter int unsigned NP = `VTCE_PORTS,
  parameter int unsigned PW = $clog2(NP)
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_in,
  // Ingress byte stream
  input  wire logic                     in_valid_in,
  output logic                          in_ready_out,
  input  wire logic [7:0]               in_data_in,
  input  wire logic                     in_last_in,
  input  wire logic [PW-1:0]            in_rx_port_in,
  input  wire logic [PW-1:0]            in_tx_port_in,
  // Egress byte stream with fresh FCS
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in,
  output logic [7:0]                    out_data_out,
  output logic                          out_last_out,
  // Per-port configuration
  input  wire logic [NP*`VTCE_VID_W-1:0] cfg_port_default_vlan_id_in,
  input  wire logic [NP*`VTCE_PCP_W-1:0] cfg_port_prio_in,
  input  wire logic [NP-1:0]            cfg_port_tagged_in,
  input  wire logic [NP-1:0]            cfg_port_tunnel_in,
  // Per-VLAN table write
  input  wire logic                     cfg_vt_wr_in,
  input  wire logic [`VTCE_VID_W-1:0]   cfg_vt_vid_in,
  input  wire logic [NP-1:0]            cfg_vt_members_in,
  input  wire logic                     cfg_vt_learn_dis_in,
  // Classification result, one pulse per frame
  output logic                          cls_valid_out,
  output logic [`VTCE_VID_W-1:0]        cls_vid_out,
  output logic [NP-1:0]                 cls_members_out,
  output logic                          cls_flood_out,
  output logic                          cls_drop_out
);

  vtce_pkg::vtce_state_e state_r;
  vtce_pkg::vtce_state_e state_nxt;
  vtce_pkg::vtce_act_e   act_r;
  vtce_pkg::vtce_act_e   act_nxt;
  vtce_pkg::vtce_vid_t   vid_r;
  vtce_pkg::vtce_vid_t   vid_c;

  logic [7:0]            hdr_r [16];
  logic [4:0]            hcnt_r;
  logic                  hdr_last_r;
  logic [PW-1:0]         rx_port_r;
  logic [PW-1:0]         tx_port_r;
  logic [4:0]            ecnt_r;
  logic [1:0]            icnt_r;
  logic [31:0]           crc_r;
  logic [2:0]            pcp_r;
  logic                  ins_svc_r;
  logic                  has_r;
  logic                  svc_r;
  logic [NP:0]           vt_rd;
  logic                  in_take;
  logic                  slot_free;
  logic                  produce;
  logic                  adv;
  logic [7:0]            obyte;
  logic                  olast;
  logic [15:0]           tpid_c;
  logic                  tag_c;
  logic                  tag_s;
  logic                  in_tun_c;
  logic                  has_c;
  logic                  drop_c;
  logic [15:0]           ins_tpid;
  logic [7:0]            ins_byte;

  // Byte-wise reflected CRC-32 step
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `VTCE_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // VLAN table, addressed by the full twelve-bit VID
  vtce_vlan_table #(
    .DW (NP + 1),
    .AW (`VTCE_VID_W)
  ) u_table (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (cfg_vt_wr_in),
    .wr_addr_in  (cfg_vt_vid_in),
    .wr_data_in  ({cfg_vt_learn_dis_in, cfg_vt_members_in}),
    .rd_addr_in  (vid_c),
    .rd_data_out (vt_rd)
  );

  // Tag detection on the EtherType after the source address
  always_comb
  begin
    tpid_c   = {hdr_r[`VTCE_TPID_HI_POS], hdr_r[`VTCE_TPID_LO_POS]};
    tag_c    = (hcnt_r >= `VTCE_HDR_BYTES) && (tpid_c == `VTCE_TPID_CUSTOMER);
    tag_s    = (hcnt_r >= `VTCE_HDR_BYTES) && (tpid_c == `VTCE_TPID_SERVICE);
    in_tun_c = cfg_port_tunnel_in[rx_port_r];
    // Tunnel ingress ignores both customer and service tags; other EtherTypes mean untagged
    has_c    = !in_tun_c && (tag_c || tag_s);
    if (has_c)
    begin
      vid_c = {hdr_r[`VTCE_TCI_HI_POS][3:0], hdr_r[`VTCE_TCI_LO_POS]};
    end
    else
    begin
      vid_c = cfg_port_default_vlan_id_in[rx_port_r*`VTCE_VID_W +: `VTCE_VID_W];
    end
  end

  // Egress membership and tag edit decision
  always_comb
  begin
    drop_c = (32'(tx_port_r) >= NP) || !vt_rd[tx_port_r];
    if (cfg_port_tunnel_in[tx_port_r])
    begin
      act_nxt = (has_r && svc_r) ? vtce_pkg::VTCE_A_DEL : vtce_pkg::VTCE_A_KEEP;
    end
    else if (cfg_port_tagged_in[tx_port_r])
    begin
      act_nxt = (!has_r && hcnt_r >= `VTCE_MAC_BYTES) ? vtce_pkg::VTCE_A_INS
                                                       : vtce_pkg::VTCE_A_KEEP;
    end
    else
    begin
      act_nxt = has_r ? vtce_pkg::VTCE_A_DEL : vtce_pkg::VTCE_A_KEEP;
    end
  end

  // Inserted tag: TPID, then priority, format bit and VID
  always_comb
  begin
    ins_tpid = ins_svc_r ? `VTCE_TPID_SERVICE : `VTCE_TPID_CUSTOMER;
    unique case (icnt_r)
      2'h0:    ins_byte = ins_tpid[15:8];
      2'h1:    ins_byte = ins_tpid[7:0];
      2'h2:    ins_byte = {pcp_r, `VTCE_CFI_VALUE, vid_r[11:8]};
      2'h3:    ins_byte = vid_r[7:0];
    endcase
  end

  // Byte source, handshakes and next state
  always_comb
  begin
    slot_free    = !out_valid_out || out_ready_in;
    produce      = 1'b0;
    obyte        = 8'h00;
    olast        = 1'b0;
    in_ready_out = 1'b0;
    state_nxt    = state_r;
    unique case (state_r)
      vtce_pkg::VTCE_S_HDR:
      begin
        in_ready_out = 1'b1;
        if (in_valid_in && (in_last_in || hcnt_r == `VTCE_HDR_BYTES - 5'h01))
        begin
          state_nxt = vtce_pkg::VTCE_S_LOOK;
        end
      end
      vtce_pkg::VTCE_S_LOOK:
      begin
        state_nxt = vtce_pkg::VTCE_S_DEC;
      end
      vtce_pkg::VTCE_S_DEC:
      begin
        state_nxt = drop_c ? vtce_pkg::VTCE_S_DROP : vtce_pkg::VTCE_S_MAC;
      end
      vtce_pkg::VTCE_S_MAC:
      begin
        if (ecnt_r < `VTCE_MAC_BYTES && ecnt_r < hcnt_r)
        begin
          produce = 1'b1;
          obyte   = hdr_r[ecnt_r[3:0]];
        end
        else
        begin
          state_nxt = (act_r == vtce_pkg::VTCE_A_INS) ? vtce_pkg::VTCE_S_INS
                                                     : vtce_pkg::VTCE_S_REST;
        end
      end
      vtce_pkg::VTCE_S_INS:
      begin
        produce = 1'b1;
        obyte   = ins_byte;
        if (slot_free && icnt_r == `VTCE_LAST_TAG_BYTE)
        begin
          state_nxt = vtce_pkg::VTCE_S_REST;
        end
      end
      vtce_pkg::VTCE_S_REST:
      begin
        if (ecnt_r < hcnt_r)
        begin
          produce = 1'b1;
          obyte   = hdr_r[ecnt_r[3:0]];
        end
        else
        begin
          state_nxt = hdr_last_r ? vtce_pkg::VTCE_S_FCS : vtce_pkg::VTCE_S_BODY;
        end
      end
      vtce_pkg::VTCE_S_BODY:
      begin
        in_ready_out = slot_free;
        produce      = in_valid_in;
        obyte        = in_data_in;
        if (in_valid_in && slot_free && in_last_in)
        begin
          state_nxt = vtce_pkg::VTCE_S_FCS;
        end
      end
      vtce_pkg::VTCE_S_FCS:
      begin
        produce = 1'b1;
        obyte   = ~crc_r[7:0];
        olast   = (icnt_r == `VTCE_LAST_FCS_BYTE);
        if (slot_free && olast)
        begin
          state_nxt = vtce_pkg::VTCE_S_HDR;
        end
      end
      vtce_pkg::VTCE_S_DROP:
      begin
        in_ready_out = !hdr_last_r;
        if (hdr_last_r || (in_valid_in && in_last_in))
        begin
          state_nxt = vtce_pkg::VTCE_S_HDR;
        end
      end
      default:
      begin
        state_nxt = vtce_pkg::VTCE_S_HDR;
      end
    endcase
    adv     = produce && slot_free;
    in_take = in_valid_in && in_ready_out;
  end

  // Sequence state
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_r <= vtce_pkg::VTCE_S_HDR;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Header capture: MAC addresses plus one possible tag
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      hcnt_r     <= 5'h00;
      hdr_last_r <= 1'b0;
      rx_port_r  <= '0;
      tx_port_r  <= '0;
      for (int i = 0; i < 16; i++)
      begin
        hdr_r[i] <= 8'h00;
      end
    end
    else if (state_r == vtce_pkg::VTCE_S_HDR && in_take)
    begin
      hdr_r[hcnt_r[3:0]] <= in_data_in;
      hcnt_r             <= hcnt_r + 5'h01;
      hdr_last_r         <= in_last_in;
      if (hcnt_r == 5'h00)
      begin
        rx_port_r <= in_rx_port_in;
        tx_port_r <= in_tx_port_in;
      end
    end
    else if (state_r != vtce_pkg::VTCE_S_HDR && state_nxt == vtce_pkg::VTCE_S_HDR)
    begin
      hcnt_r     <= 5'h00;
      hdr_last_r <= 1'b0;
    end
  end

  // Classification latch while the table read is in flight
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      vid_r     <= '0;
      has_r     <= 1'b0;
      svc_r     <= 1'b0;
      ins_svc_r <= 1'b0;
      pcp_r     <= 3'h0;
      act_r     <= vtce_pkg::VTCE_A_KEEP;
    end
    else if (state_r == vtce_pkg::VTCE_S_LOOK)
    begin
      vid_r     <= vid_c;
      has_r     <= has_c;
      svc_r     <= tag_s;
      ins_svc_r <= in_tun_c;
      pcp_r     <= has_c ? hdr_r[`VTCE_TCI_HI_POS][7:5]
                         : cfg_port_prio_in[rx_port_r*`VTCE_PCP_W +: `VTCE_PCP_W];
    end
    else if (state_r == vtce_pkg::VTCE_S_DEC)
    begin
      act_r <= act_nxt;
    end
  end

  // Header walk pointer; removal skips the four tag bytes
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || state_r == vtce_pkg::VTCE_S_DEC)
    begin
      ecnt_r <= 5'h00;
    end
    else if (state_r == vtce_pkg::VTCE_S_MAC && state_nxt != vtce_pkg::VTCE_S_MAC)
    begin
      ecnt_r <= (act_r == vtce_pkg::VTCE_A_DEL) ? `VTCE_HDR_BYTES : `VTCE_MAC_BYTES;
    end
    // Only header bytes move the pointer; inserted tag bytes must not skip bytes 12 to 15
    else if (adv && (state_r == vtce_pkg::VTCE_S_MAC || state_r == vtce_pkg::VTCE_S_REST))
    begin
      ecnt_r <= ecnt_r + 5'h01;
    end
  end

  // Tag and FCS byte counter
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || state_nxt != state_r)
    begin
      icnt_r <= 2'h0;
    end
    else if (adv)
    begin
      icnt_r <= icnt_r + 2'h1;
    end
  end

  // Running CRC over every byte sent, then shifted out
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || state_r == vtce_pkg::VTCE_S_DEC)
    begin
      crc_r <= `VTCE_CRC_INIT;
    end
    else if (adv && state_r == vtce_pkg::VTCE_S_FCS)
    begin
      crc_r <= crc_r >> 8;
    end
    else if (adv)
    begin
      crc_r <= crc_step(crc_r, obyte);
    end
  end

  // Output register stage
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out  <= 8'h00;
      out_last_out  <= 1'b0;
    end
    else if (slot_free)
    begin
      out_valid_out <= adv;
      out_data_out  <= obyte;
      out_last_out  <= olast;
    end
  end

  // Classification report to the forwarding engine
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cls_valid_out   <= 1'b0;
      cls_vid_out     <= '0;
      cls_members_out <= '0;
      cls_flood_out   <= 1'b0;
      cls_drop_out    <= 1'b0;
    end
    else
    begin
      cls_valid_out <= (state_r == vtce_pkg::VTCE_S_DEC);
      if (state_r == vtce_pkg::VTCE_S_DEC)
      begin
        cls_vid_out     <= vid_r;
        cls_members_out <= vt_rd[NP-1:0];
        cls_flood_out   <= vt_rd[NP];
        cls_drop_out    <= drop_c;
      end
    end
  end

endmodule

`default_nettype wire

// *** test/vtce_vlan_tag_edit_assertions.sv ***
// Checker for the VLAN classify and tag edit block.
// Assumes binding into vtce_vlan_tag_edit; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module vtce_vlan_tag_edit_assertions #(
  parameter int unsigned NP = 10,
  parameter int unsigned PW = 4
) (
  input wire logic             clk_sys_in,
  input wire logic             rst_in,
  input wire logic             in_valid_in,
  input wire logic             in_ready_out,
  input wire logic [7:0]       in_data_in,
  input wire logic             in_last_in,
  input wire logic [PW-1:0]    in_rx_port_in,
  input wire logic [PW-1:0]    in_tx_port_in,
  input wire logic             out_valid_out,
  input wire logic             out_ready_in,
  input wire logic [7:0]       out_data_out,
  input wire logic             out_last_out,
  input wire logic [NP*12-1:0] cfg_port_default_vlan_id_in,
  input wire logic [NP-1:0]    cfg_port_tagged_in,
  input wire logic [NP-1:0]    cfg_port_tunnel_in,
  input wire logic             cfg_vt_wr_in,
  input wire logic [11:0]      cfg_vt_vid_in,
  input wire logic [NP-1:0]    cfg_vt_members_in,
  input wire logic             cfg_vt_learn_dis_in,
  input wire logic             cls_valid_out,
  input wire logic [11:0]      cls_vid_out,
  input wire logic [NP-1:0]    cls_members_out,
  input wire logic             cls_flood_out,
  input wire logic             cls_drop_out
);
  logic          inf_r;
  logic [5:0]    idx_r;
  logic [5:0]    oidx_r;
  logic [PW-1:0] rx_r;
  logic [PW-1:0] tx_r;
  logic [31:0]   hdr_r;
  logic [NP:0]   tab_r [4096];
  logic [5:0]    bi;
  logic          tk;
  logic          tagd;
  logic          ins;
  logic          push;

  // Ingress byte position and expected edit of the current frame
  assign tk = in_valid_in && in_ready_out;
  assign bi = inf_r ? idx_r : 6'h00;
  assign tagd = idx_r >= 6'h10 && !cfg_port_tunnel_in[rx_r]
    && (hdr_r[31:16] == 16'h8100 || hdr_r[31:16] == 16'h88A8);
  assign ins = !tagd && !cfg_port_tunnel_in[rx_r] && cfg_port_tagged_in[tx_r]
    && !cfg_port_tunnel_in[tx_r] && idx_r >= 6'h0C;
  assign push = cfg_port_tunnel_in[rx_r] && cfg_port_tagged_in[tx_r]
    && !cfg_port_tunnel_in[tx_r] && idx_r >= 6'h0C;

  // Frame tracking, ports and header bytes 12 to 15
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      inf_r <= 1'b0;
      idx_r <= 6'h00;
    end
    else if (tk)
    begin
      inf_r <= !in_last_in;
      idx_r <= (bi == 6'h3F) ? bi : bi + 6'h01;
      if (!inf_r)
      begin
        rx_r  <= in_rx_port_in;
        tx_r  <= in_tx_port_in;
        hdr_r <= 32'h00000000;
      end
      if (bi >= 6'h0C && bi <= 6'h0F)
        hdr_r[8*(15-bi) +: 8] <= in_data_in;
    end
  end

  // Shadow of the per-VLAN table
  always_ff @(posedge clk_sys_in)
    if (cfg_vt_wr_in)
      tab_r[cfg_vt_vid_in] <= {cfg_vt_learn_dis_in, cfg_vt_members_in};

  // Egress byte position
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      oidx_r <= 6'h00;
    else if (out_valid_out && out_ready_in)
      oidx_r <= out_last_out ? 6'h00 : oidx_r + 6'h01;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_hdr_done;
    tk && inf_r && idx_r == 6'h0F;
  endsequence

  sequence s_tpid_slot;
    out_valid_out && oidx_r == 6'h0C;
  endsequence

  a_untag_default_vid: assert property (cls_valid_out && !tagd |->
    cls_vid_out == cfg_port_default_vlan_id_in[rx_r*12 +: 12]) else $error("bad default vid");
  a_tag_vid: assert property (cls_valid_out && tagd |->
    cls_vid_out == hdr_r[11:0]) else $error("bad tag vid");
  a_member_drop: assert property (cls_valid_out |->
    cls_drop_out == !(tx_r < NP && cls_members_out[tx_r])) else $error("bad drop");
  a_table_map: assert property (cls_valid_out |->
    {cls_flood_out, cls_members_out} == tab_r[cls_vid_out]) else $error("bad table map");
  a_drop_silent: assert property (cls_valid_out && cls_drop_out |->
    (!out_valid_out) [*8]) else $error("dropped frame sent");
  a_hdr_ready: assert property (inf_r && idx_r < 6'h10 |-> in_ready_out)
    else $error("header not accepted");
  a_out_hold: assert property (out_valid_out && !out_ready_in |=> out_valid_out
    && $stable(out_data_out) && $stable(out_last_out)) else $error("egress byte lost");
  a_cls_latency: assert property (s_hdr_done |-> ##3 cls_valid_out)
    else $error("late classification");
  a_insert_tpid: assert property (s_tpid_slot |-> !ins || out_data_out == 8'h81)
    else $error("bad customer tpid");
  a_push_tpid: assert property (s_tpid_slot |-> !push || out_data_out == 8'h88)
    else $error("bad provider tpid");
endmodule

bind vtce_vlan_tag_edit vtce_vlan_tag_edit_assertions #(.NP(NP), .PW(PW)) u_chk (.*);

`default_nettype wire

// *** test/vtce_sink_model.sv ***
// Egress port model: takes bytes, optionally stalling.
// Assumes the egress valid/ready handshake of the block.
`timescale 1ns/1ps
`default_nettype none

module vtce_sink_model (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic stall_in,
  output logic      ready_out
);
  logic [1:0] cnt_r;

  // Ready one cycle in four while stalling
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cnt_r     <= 2'h0;
      ready_out <= 1'b1;
    end
    else
    begin
      cnt_r     <= cnt_r + 2'h1;
      ready_out <= !stall_in || cnt_r == 2'h3;
    end
  end
endmodule

`default_nettype wire

// *** test/vtce_vlan_tag_edit_tb_top.sv ***
// Testbench for the VLAN classify and tag edit block.
// Assumes the design, checker and sink model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module vtce_vlan_tag_edit_tb_top;
  typedef logic [7:0] vtce_bq_t[$];
  localparam int unsigned NP = 10;
  localparam int unsigned PW = 4;
  logic clk_sys_in, rst_in, in_valid_in, in_ready_out, in_last_in, slow;
  logic out_valid_out, out_ready_in, out_last_out, cfg_vt_wr_in, cfg_vt_learn_dis_in;
  logic cls_valid_out, cls_flood_out, cls_drop_out, cfl, cdr, seen_last;
  logic [7:0] in_data_in, out_data_out;
  logic [PW-1:0] in_rx_port_in, in_tx_port_in;
  logic [NP*12-1:0] cfg_port_default_vlan_id_in;
  logic [NP*3-1:0] cfg_port_prio_in;
  logic [NP-1:0] cfg_port_tagged_in, cfg_port_tunnel_in, cfg_vt_members_in, cls_members_out;
  logic [11:0] cfg_vt_vid_in, cls_vid_out, cvid;
  int err_total, n_compared, ncls;
  vtce_bq_t oq;

  vtce_vlan_tag_edit #(.NP(NP), .PW(PW)) DUT (.*);
  vtce_sink_model u_sink (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .stall_in(slow),
    .ready_out(out_ready_in));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Collect egress bytes and classification results
  always @(posedge clk_sys_in)
  begin
    if (out_valid_out && out_ready_in)
    begin
      oq.push_back(out_data_out);
      if (out_last_out) seen_last = 1'b1;
    end
    if (cls_valid_out)
    begin
      ncls++;
      cvid = cls_vid_out;
      cfl = cls_flood_out;
      cdr = cls_drop_out;
    end
  end

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 300)
    begin
      err_total++;
      $display("MISMATCH wait_bound expected done seen timeout");
      end_sim();
    end
  endtask

  // Frame: MAC bytes, up to two tags, EtherType, payload
  function automatic vtce_bq_t mk(input int nt, input logic [15:0] t1, input logic [15:0] c1,
                                  input logic [15:0] t2, input logic [15:0] c2);
    vtce_bq_t q;
    for (int i = 0; i < 12; i++) q.push_back(8'(i * 16 + 1));
    if (nt > 0) q = {q, t1[15:8], t1[7:0], c1[15:8], c1[7:0]};
    if (nt > 1) q = {q, t2[15:8], t2[7:0], c2[15:8], c2[7:0]};
    q = {q, 8'h08, 8'h00};
    for (int i = 0; i < 8; i++) q.push_back(8'(i * 37));
    return q;
  endfunction

  // Expected egress: keep, insert or delete a tag, then reflected CRC-32
  function automatic vtce_bq_t edit(input vtce_bq_t q, input int act, input logic [15:0] tp,
                                    input logic [15:0] tc);
    vtce_bq_t r;
    logic [31:0] c;
    if (act == 1) r = {q[0:11], tp[15:8], tp[7:0], tc[15:8], tc[7:0], q[12:$]};
    else if (act == 2) r = {q[0:11], q[16:$]};
    else r = q;
    c = 32'hFFFFFFFF;
    foreach (r[i])
    begin
      c = c ^ {24'h000000, r[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    c = ~c;
    return {r, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction

  task automatic wt(input logic [11:0] v, input logic [NP-1:0] m, input logic ld);
    cfg_vt_vid_in = v;
    cfg_vt_members_in = m;
    cfg_vt_learn_dis_in = ld;
    cfg_vt_wr_in = 1'b1;
    @(posedge clk_sys_in);
    #1 cfg_vt_wr_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask

  // Send one frame, wait for its outcome and judge it
  task automatic run(input vtce_bq_t f, input logic [PW-1:0] rx, input logic [PW-1:0] tx,
                     input vtce_bq_t ex, input logic [11:0] vid, input logic fl,
                     input logic drop);
    int n;
    oq = {};
    seen_last = 1'b0;
    ncls = 0;
    in_rx_port_in = rx;
    in_tx_port_in = tx;
    foreach (f[i])
    begin
      in_valid_in = 1'b1;
      in_data_in = f[i];
      in_last_in = (i == f.size() - 1);
      n = 0;
      while (in_ready_out !== 1'b1 && n < 300)
      begin
        @(posedge clk_sys_in);
        #1 n++;
      end
      tmo(n);
      @(posedge clk_sys_in);
      #1;
    end
    in_valid_in = 1'b0;
    in_last_in = 1'b0;
    n = 0;
    while (!(drop ? ncls > 0 : seen_last) && n < 300)
    begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    tmo(n);
    if (drop)
    begin
      repeat (20) @(posedge clk_sys_in);
      #1;
    end
    chk("cls_count", ncls, 1);
    chk("cls_vid", cvid, vid);
    chk("cls_flood", cfl, fl);
    chk("cls_drop", cdr, drop);
    chk("out_len", oq.size(), drop ? 0 : ex.size());
    if (!drop) foreach (ex[i]) if (i < oq.size()) chk("out_byte", oq[i], ex[i]);
  endtask

  task automatic t_insert;
    vtce_bq_t f = mk(0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    vtce_bq_t g = mk(1, 16'h9100, 16'h0ABC, 16'h0000, 16'h0000);
    run(f, 4'h0, 4'h1, edit(f, 1, 16'h8100, 16'hA005), 12'h005, 1'b0, 1'b0);
    run(g, 4'h0, 4'h1, edit(g, 1, 16'h8100, 16'hA005), 12'h005, 1'b0, 1'b0);
  endtask

  task automatic t_strip_keep;
    vtce_bq_t f = mk(1, 16'h8100, 16'hC007, 16'h0000, 16'h0000);
    vtce_bq_t g = mk(1, 16'h8100, 16'h2005, 16'h0000, 16'h0000);
    vtce_bq_t h = mk(1, 16'h8100, 16'h0FFF, 16'h0000, 16'h0000);
    run(f, 4'h1, 4'h3, edit(f, 2, 16'h0000, 16'h0000), 12'h007, 1'b1, 1'b0);
    run(g, 4'h0, 4'h2, edit(g, 0, 16'h0000, 16'h0000), 12'h005, 1'b0, 1'b0);
    run(h, 4'h0, 4'h1, edit(h, 0, 16'h0000, 16'h0000), 12'hFFF, 1'b0, 1'b0);
  endtask

  task automatic t_drop;
    vtce_bq_t f = mk(0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    run(f, 4'h0, 4'h3, f, 12'h005, 1'b0, 1'b1);
    run(f, 4'h0, 4'hF, f, 12'h005, 1'b0, 1'b1);
  endtask

  task automatic t_tunnel;
    vtce_bq_t f = mk(1, 16'h8100, 16'h4009, 16'h0000, 16'h0000);
    vtce_bq_t g = mk(2, 16'h88A8, 16'h4123, 16'h8100, 16'h4009);
    run(f, 4'h4, 4'h2, edit(f, 1, 16'h88A8, 16'h4123), 12'h123, 1'b1, 1'b0);
    run(g, 4'h2, 4'h4, edit(g, 2, 16'h0000, 16'h0000), 12'h123, 1'b1, 1'b0);
  endtask

  task automatic t_runtime;
    vtce_bq_t f = mk(0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    cfg_port_default_vlan_id_in[11:0] = 12'h007;
    run(f, 4'h0, 4'h3, edit(f, 0, 16'h0000, 16'h0000), 12'h007, 1'b1, 1'b0);
  endtask

  // Configure, reset, program the table, then run the scenarios
  initial
  begin
    {rst_in, in_valid_in, in_last_in, slow, cfg_vt_wr_in, cfg_vt_learn_dis_in} = 6'h20;
    {in_data_in, in_rx_port_in, in_tx_port_in, cfg_vt_vid_in, cfg_vt_members_in} = '0;
    err_total = 0;
    n_compared = 0;
    for (int p = 0; p < NP; p++) cfg_port_default_vlan_id_in[p*12 +: 12] = 12'h001;
    for (int p = 0; p < NP; p++) cfg_port_prio_in[p*3 +: 3] = 3'h5;
    cfg_port_default_vlan_id_in[11:0] = 12'h005;
    cfg_port_default_vlan_id_in[23:12] = 12'h007;
    cfg_port_default_vlan_id_in[59:48] = 12'h123;
    cfg_port_prio_in[14:12] = 3'h2;
    cfg_port_tagged_in = 10'h006;
    cfg_port_tunnel_in = 10'h010;
    repeat (3) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    wt(12'h005, 10'h007, 1'b0);
    wt(12'h007, 10'h00A, 1'b1);
    wt(12'h123, 10'h014, 1'b1);
    wt(12'hFFF, 10'h002, 1'b0);
    t_insert();
    slow = 1'b1;
    t_strip_keep();
    t_drop();
    t_tunnel();
    slow = 1'b0;
    t_runtime();
    end_sim();
  end
endmodule

`default_nettype wire
